// ==== hdl/status_event_registers.sv ====
// module: three transition-filtered, read-clearing status event registers
module status_event_registers
	import status_event_pkg::*;
(
	// clock and reset
	input  wire logic         clk_sys,
	input  wire logic         srst,
	// instrument condition levels, same clock domain
	input  wire status_word_t cond,
	// transition filters and event enables
	input  wire status_word_t rising_filter,
	input  wire status_word_t falling_filter,
	input  wire status_word_t event_enable,
	// remote status query port
	input  wire logic         query_valid,
	input  wire query_sel_t   query_sel,
	output answer_t           answer,
	// summaries toward the next register set and the front panel
	output logic              meas_summary,
	output logic              doubtful_summary,
	output logic              activity_summary,
	output logic              error_lamp
);

	// ============================================================
	// state
	// ============================================================
	typedef struct packed {
		status_word_t prev;
		status_word_t events;
		answer_t      answer;
	} state_t;

	state_t       state_reg;
	state_t       state_next;
	status_word_t hit;
	status_word_t rise;
	status_word_t fall;
	status_word_t clear;

	// ============================================================
	// helpers
	// ============================================================
	// binary to five packed decimal digits by shift and add-three
	function automatic logic [DEC_W-1:0] to_decimal(input logic [WORD_W-1:0] bin);
		logic [DEC_W+WORD_W-1:0] sh;
		sh = {{DEC_W{1'b0}}, bin};
		for (int i = 0; i < WORD_W; i++) begin
			for (int d = 0; d < DEC_W / 4; d++) begin
				if (sh[WORD_W + 4*d +: 4] >= 4'h5) begin
					sh[WORD_W + 4*d +: 4] = sh[WORD_W + 4*d +: 4] + 4'h3;
				end
			end
			sh = sh << 1;
		end
		return sh[DEC_W+WORD_W-1:WORD_W];
	endfunction : to_decimal

	// events chosen by the per-bit filter, limited to the defined positions
	function automatic logic [WORD_W-1:0] filter_hits(
		input logic [WORD_W-1:0] up,
		input logic [WORD_W-1:0] down,
		input logic [WORD_W-1:0] rise_sel,
		input logic [WORD_W-1:0] fall_sel,
		input logic [WORD_W-1:0] used,
		input logic [WORD_W-1:0] fall_ok
	);
		return ((up & rise_sel) | (down & fall_sel & fall_ok)) & used;
	endfunction : filter_hits

	// ============================================================
	// edge detection
	// ============================================================
	// a level compared with its value one clock earlier
	assign rise = cond & ~state_reg.prev;
	assign fall = ~cond & state_reg.prev;

	// per-register filtered hits; bit meanings fixed by the masks
	assign hit.meas = filter_hits(rise.meas, fall.meas, rising_filter.meas,
		falling_filter.meas, MEAS_USED, MEAS_FALL_OK);
	assign hit.doubtful = filter_hits(rise.doubtful, fall.doubtful, rising_filter.doubtful,
		falling_filter.doubtful, DOUBT_USED, DOUBT_FALL_OK);
	assign hit.activity = filter_hits(rise.activity, fall.activity, rising_filter.activity,
		falling_filter.activity, ACTIV_USED, ACTIV_FALL_OK);

	// read side effect: whole register cleared when queried
	assign clear.meas     = {WORD_W{query_valid && query_sel == QUERY_MEAS}};
	assign clear.doubtful = {WORD_W{query_valid && query_sel == QUERY_DOUBTFUL}};
	assign clear.activity = {WORD_W{query_valid && query_sel == QUERY_ACTIVITY}};

	// ============================================================
	// next state
	// ============================================================
	always_comb begin
		logic [WORD_W-1:0] value;
		value = '0;
		state_next = state_reg;
		state_next.prev = cond;
		// a new hit wins over the read clear
		state_next.events = (state_reg.events & ~clear) | hit;
		// answer: value before the clear
		case (query_sel)
			QUERY_MEAS: begin
				value = state_reg.events.meas;
			end
			QUERY_DOUBTFUL: begin
				value = state_reg.events.doubtful;
			end
			QUERY_ACTIVITY: begin
				value = state_reg.events.activity;
			end
			QUERY_COMPLIANCE: begin
				value = {{(WORD_W-1){1'b0}}, cond.meas[MEAS_SRC_COMPLY]};
			end
			default: begin
				value = '0;
			end
		endcase
		state_next.answer.valid = query_valid;
		if (query_valid) begin
			state_next.answer.bin = value;
			state_next.answer.dec = to_decimal(value);
		end
	end

	// state register
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state_reg.prev   <= '{activity: PREV_RESET, doubtful: PREV_RESET, meas: PREV_RESET};
			state_reg.events <= '{activity: EVENT_RESET, doubtful: EVENT_RESET, meas: EVENT_RESET};
			state_reg.answer <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// ============================================================
	// outputs
	// ============================================================
	assign answer           = state_reg.answer;
	assign meas_summary     = |(state_reg.events.meas & event_enable.meas);
	assign doubtful_summary = |(state_reg.events.doubtful & event_enable.doubtful);
	assign activity_summary = |(state_reg.events.activity & event_enable.activity);
	assign error_lamp       = |(cond.doubtful & DOUBT_USED);

	// ============================================================
	// checks
	// ============================================================
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (srst);

	// a read with no new hit leaves the register empty
	AST_READ_CLEARS: assert property (
		(query_valid && query_sel == QUERY_MEAS && hit.meas == '0) |=> state_reg.events.meas == '0
	) else $error("measurement register not cleared by read");

	// answer carries the pre-read value one cycle later
	AST_ANSWER_VALUE: assert property (
		(query_valid && query_sel == QUERY_DOUBTFUL) |=>
			(answer.valid && answer.bin == $past(state_reg.events.doubtful))
	) else $error("query answer does not match register");

	// decimal digits encode the binary answer
	AST_DECIMAL_FORM: assert property (
		answer.valid |-> (32'(answer.dec[3:0]) + 32'(answer.dec[7:4]) * 10
			+ 32'(answer.dec[11:8]) * 100 + 32'(answer.dec[15:12]) * 1000
			+ 32'(answer.dec[19:16]) * 10000) == 32'(answer.bin)
	) else $error("decimal answer wrong");

	// rising edge under a rising filter latches the bit
	AST_RISE_SETS: assert property (
		((cond.activity & ~$past(cond.activity) & rising_filter.activity & ACTIV_USED) != '0)
			|=> (state_reg.events.activity & $past(cond.activity & ~state_reg.prev.activity
				& rising_filter.activity & ACTIV_USED)) != '0
	) else $error("rising transition missed");

	// falling edge under a falling filter latches the bit
	AST_FALL_SETS: assert property (
		(state_reg.prev.meas[MEAS_OVER_RANGE] && !cond.meas[MEAS_OVER_RANGE]
			&& falling_filter.meas[MEAS_OVER_RANGE]) |=> state_reg.events.meas[MEAS_OVER_RANGE]
	) else $error("falling transition missed");

	// rise-only bits ignore a falling edge
	AST_RISE_ONLY: assert property (
		(state_reg.events.meas[MEAS_TRANSIENT] == 1'b0 && !rising_filter.meas[MEAS_TRANSIENT])
			|=> !state_reg.events.meas[MEAS_TRANSIENT]
	) else $error("rise-only bit set without rising filter");

	// top bit and unused positions stay clear
	AST_UNUSED_ZERO: assert property (
		(state_reg.events.meas & ~MEAS_USED) == '0 && (state_reg.events.doubtful & ~DOUBT_USED) == '0
			&& (state_reg.events.activity & ~ACTIV_USED) == '0
			&& !state_reg.events.meas[ALWAYS_ZERO_BIT]
	) else $error("unused event bit set");

	// error lamp follows the doubtful conditions
	AST_ERROR_LAMP: assert property (
		$rose(|(cond.doubtful & DOUBT_USED)) |-> error_lamp ##1 (error_lamp || cond.doubtful == '0
			|| (cond.doubtful & DOUBT_USED) == '0)
	) else $error("error lamp not lit");

	// compliance answer mirrors the compliance level
	AST_COMPLIANCE: assert property (
		(query_valid && query_sel == QUERY_COMPLIANCE) |=>
			answer.bin == {{(WORD_W-1){1'b0}}, $past(cond.meas[MEAS_SRC_COMPLY])}
	) else $error("compliance answer wrong");

	// summary only from enabled bits
	AST_SUMMARY_MASK: assert property (
		(event_enable.meas == '0) |-> !meas_summary
	) else $error("masked event reached summary");

	// a latched bit holds while the register is not read
	AST_HOLD_UNTIL_READ: assert property (
		(state_reg.events.activity[0] && !(query_valid && query_sel == QUERY_ACTIVITY))
			|=> state_reg.events.activity[0]
	) else $error("event bit lost without a read");

	// hit in the read cycle survives the clear
	AST_SET_WINS: assert property (
		(query_valid && query_sel == QUERY_MEAS && hit.meas != '0) |=>
			(state_reg.events.meas & $past(hit.meas)) == $past(hit.meas)
	) else $error("event lost in read cycle");

	// reading the doubtful register empties it too
	AST_READ_CLEARS_DOUBT: assert property (
		(query_valid && query_sel == QUERY_DOUBTFUL && hit.doubtful == '0) |=> state_reg.events.doubtful == '0
	) else $error("doubtful register not cleared by read");

	// measurement answer carries the pre-read value
	AST_ANSWER_MEAS: assert property (
		(query_valid && query_sel == QUERY_MEAS) |=> answer.valid && answer.bin == $past(state_reg.events.meas)
	) else $error("measurement answer does not match register");

	// no answer without a query
	AST_ANSWER_PULSE: assert property (
		!query_valid |=> !answer.valid
	) else $error("answer valid without a query");

	// answer data stands between queries
	AST_ANSWER_HOLDS: assert property (
		!query_valid |=> $stable(answer.bin) && $stable(answer.dec)
	) else $error("answer changed without a query");

	// over-range rising edge latches bit 0
	AST_OVER_RANGE_RISE: assert property (
		(cond.meas[MEAS_OVER_RANGE] && !state_reg.prev.meas[MEAS_OVER_RANGE]
			&& rising_filter.meas[MEAS_OVER_RANGE]) |=> state_reg.events.meas[MEAS_OVER_RANGE]
	) else $error("over-range rise missed");

	// leaving the first low bound latches bit 1 under a falling filter
	AST_BELOW_LOW_ONE_FALL: assert property (
		(state_reg.prev.meas[MEAS_BELOW_LOW_1] && !cond.meas[MEAS_BELOW_LOW_1]
			&& falling_filter.meas[MEAS_BELOW_LOW_1]) |=> state_reg.events.meas[MEAS_BELOW_LOW_1]
	) else $error("low bound fall missed");

	// return from under-range latches bit 6 under a falling filter
	AST_UNDER_RANGE_FALL: assert property (
		(state_reg.prev.meas[MEAS_UNDER_RANGE] && !cond.meas[MEAS_UNDER_RANGE]
			&& falling_filter.meas[MEAS_UNDER_RANGE]) |=> state_reg.events.meas[MEAS_UNDER_RANGE]
	) else $error("under-range fall missed");

	// pretrigger completion latches bit 11 under a falling filter
	AST_PRETRIG_FALL: assert property (
		(state_reg.prev.meas[MEAS_BUF_PRETRIG] && !cond.meas[MEAS_BUF_PRETRIG]
			&& falling_filter.meas[MEAS_BUF_PRETRIG]) |=> state_reg.events.meas[MEAS_BUF_PRETRIG]
	) else $error("pretrigger fall missed");

	// compliance bit sets on a rising edge only
	AST_COMPLY_RISE_ONLY: assert property (
		(!state_reg.events.meas[MEAS_SRC_COMPLY] && !(cond.meas[MEAS_SRC_COMPLY]
			&& !state_reg.prev.meas[MEAS_SRC_COMPLY])) |=> !state_reg.events.meas[MEAS_SRC_COMPLY]
	) else $error("compliance bit set without a rise");

	// calibration fault bit is not set by its condition clearing
	AST_CAL_RISE_ONLY: assert property (
		(!state_reg.events.doubtful[DOUBT_CAL_BAD] && !(cond.doubtful[DOUBT_CAL_BAD]
			&& !state_reg.prev.doubtful[DOUBT_CAL_BAD])) |=> !state_reg.events.doubtful[DOUBT_CAL_BAD]
	) else $error("calibration bit set without a rise");

	// sequence abort latches bit 12 on its rising edge
	AST_SEQ_ABORT_RISE: assert property (
		(cond.doubtful[DOUBT_SEQ_ABORT] && !state_reg.prev.doubtful[DOUBT_SEQ_ABORT]
			&& rising_filter.doubtful[DOUBT_SEQ_ABORT]) |=> state_reg.events.doubtful[DOUBT_SEQ_ABORT]
	) else $error("sequence abort rise missed");

	// later successful command latches bit 14 under a falling filter
	AST_WARN_FALL: assert property (
		(state_reg.prev.doubtful[DOUBT_CMD_WARN] && !cond.doubtful[DOUBT_CMD_WARN]
			&& falling_filter.doubtful[DOUBT_CMD_WARN]) |=> state_reg.events.doubtful[DOUBT_CMD_WARN]
	) else $error("command warning fall missed");

	// lamp is lit exactly while a used doubtful condition is active
	AST_LAMP_LEVEL: assert property (
		error_lamp == ((cond.doubtful & DOUBT_USED) != '0)
	) else $error("error lamp level wrong");

	// end of calibration latches activity bit 0 under a falling filter
	AST_CALIBRATING_FALL: assert property (
		(state_reg.prev.activity[ACTIV_CALIBRATING] && !cond.activity[ACTIV_CALIBRATING]
			&& falling_filter.activity[ACTIV_CALIBRATING]) |=> state_reg.events.activity[ACTIV_CALIBRATING]
	) else $error("calibration end missed");

	// entering an arm layer latches activity bit 6
	AST_WAIT_ARM_RISE: assert property (
		(cond.activity[ACTIV_WAIT_ARM] && !state_reg.prev.activity[ACTIV_WAIT_ARM]
			&& rising_filter.activity[ACTIV_WAIT_ARM]) |=> state_reg.events.activity[ACTIV_WAIT_ARM]
	) else $error("arm wait rise missed");

	// a compliance query clears no measurement event
	AST_COMPLIANCE_KEEPS: assert property (
		(query_valid && query_sel == QUERY_COMPLIANCE) |=>
			state_reg.events.meas == $past(state_reg.events.meas | hit.meas)
	) else $error("compliance query disturbed the register");

	// an enabled set bit raises the summary
	AST_SUMMARY_SETS: assert property (
		((state_reg.events.doubtful & event_enable.doubtful) != '0) |-> doubtful_summary
	) else $error("enabled event missing from summary");

endmodule : status_event_registers

// ==== hdl/status_event_pkg.sv ====
// package: field layouts, masks and query codes for the status event registers
package status_event_pkg;

	// ============================================================
	// register words
	// ============================================================
	localparam int WORD_W  = 16;
	localparam int DEC_W   = 20;      // five decimal digits, enough for 65535

	// one 16-bit word for each of the three event registers
	typedef struct packed {
		logic [WORD_W-1:0] activity;
		logic [WORD_W-1:0] doubtful;
		logic [WORD_W-1:0] meas;
	} status_word_t;

	// ============================================================
	// reset values
	// ============================================================
	localparam logic [WORD_W-1:0] EVENT_RESET = 16'h0000;
	localparam logic [WORD_W-1:0] PREV_RESET  = 16'h0000;

	// ============================================================
	// bit positions
	// ============================================================
	localparam int MEAS_OVER_RANGE    = 0;
	localparam int MEAS_BELOW_LOW_1   = 1;
	localparam int MEAS_ABOVE_HIGH_1  = 2;
	localparam int MEAS_BELOW_LOW_2   = 3;
	localparam int MEAS_ABOVE_HIGH_2  = 4;
	localparam int MEAS_READING_READY = 5;
	localparam int MEAS_UNDER_RANGE   = 6;
	localparam int MEAS_BUF_NONEMPTY  = 7;
	localparam int MEAS_BUF_HALF      = 8;
	localparam int MEAS_BUF_FILLED    = 9;
	localparam int MEAS_BUF_PRETRIG   = 11;
	localparam int MEAS_TRANSIENT     = 12;
	localparam int MEAS_SRC_COMPLY    = 14;
	localparam int ALWAYS_ZERO_BIT    = 15;
	// doubtful register bit positions
	localparam int DOUBT_CAL_BAD      = 8;
	localparam int DOUBT_SEQ_ABORT    = 12;
	localparam int DOUBT_CMD_WARN     = 14;
	// activity register bit positions
	localparam int ACTIV_CALIBRATING  = 0;
	localparam int ACTIV_WAIT_ARM     = 6;

	// ============================================================
	// used and falling-capable bit masks
	// ============================================================
	localparam logic [WORD_W-1:0] MEAS_USED      = 16'h5bff;
	localparam logic [WORD_W-1:0] MEAS_FALL_OK   = 16'h0bff;  // bits 12 and 14 rise only
	localparam logic [WORD_W-1:0] DOUBT_USED     = 16'h5f13;
	localparam logic [WORD_W-1:0] DOUBT_FALL_OK  = 16'h4e13;  // bits 8 and 12 rise only
	localparam logic [WORD_W-1:0] ACTIV_USED     = 16'h0e61;
	localparam logic [WORD_W-1:0] ACTIV_FALL_OK  = 16'h0e61;

	// ============================================================
	// query selection
	// ============================================================
	typedef enum logic [1:0] {
		QUERY_MEAS,
		QUERY_DOUBTFUL,
		QUERY_ACTIVITY,
		QUERY_COMPLIANCE
	} query_sel_t;

	// answer delivered to the remote interface
	typedef struct packed {
		logic              valid;
		logic [WORD_W-1:0] bin;
		logic [DEC_W-1:0]  dec;
	} answer_t;

endpackage : status_event_pkg

// ==== testbench/status_host_model.sv ====
// host model: issues status queries and collects the answers
module status_host_model
	import status_event_pkg::*;
(
	// clock
	input  wire logic       clk_sys,
	// answer from the block
	input  wire answer_t    answer,
	// query toward the block
	output logic            query_valid,
	output query_sel_t      query_sel
);
	timeunit 1ns;
	timeprecision 100ps;

	// ============================================================
	// query sequence
	// ============================================================
	// idle bus between queries
	initial begin
		query_valid = 1'b0;
		query_sel   = QUERY_MEAS;
	end

	// caller enters just after a rising edge; request is taken on the next edge
	task automatic ask(input query_sel_t s, output logic v, output logic [WORD_W-1:0] b,
		output logic [DEC_W-1:0] d);
		query_valid <= 1'b1;
		query_sel   <= s;
		@(posedge clk_sys);
		query_valid <= 1'b0;
		#1;
		v = answer.valid;  // valid stands one cycle only
		b = answer.bin;
		d = answer.dec;
	endtask : ask

endmodule : status_host_model

// ==== testbench/status_event_registers_tb.sv ====
// testbench: query-driven checks of the three status event registers
module status_event_registers_tb
	import status_event_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic         clk_sys = 1'b0;
	logic         srst    = 1'b1;
	status_word_t cond, rising_filter, falling_filter, event_enable;
	logic         query_valid, meas_summary, doubtful_summary, activity_summary, error_lamp;
	query_sel_t   query_sel;
	answer_t      answer;
	int           err_total       = 0;
	int           samples_checked = 0;

	// ============================================================
	// clock, design and host
	// ============================================================
	// 20 MHz system clock
	always #25 clk_sys = ~clk_sys;

	status_event_registers i_status_event_registers (.clk_sys(clk_sys), .srst(srst), .cond(cond),
		.rising_filter(rising_filter), .falling_filter(falling_filter), .event_enable(event_enable),
		.query_valid(query_valid), .query_sel(query_sel), .answer(answer), .meas_summary(meas_summary),
		.doubtful_summary(doubtful_summary), .activity_summary(activity_summary), .error_lamp(error_lamp));

	status_host_model i_status_host_model (.clk_sys(clk_sys), .answer(answer), .query_valid(query_valid),
		.query_sel(query_sel));

	// ============================================================
	// helpers
	// ============================================================
	// compare and count
	task automatic check(input logic [DEC_W-1:0] seen, input logic [DEC_W-1:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : check

	// five bcd digits of a 16-bit value
	function automatic logic [DEC_W-1:0] to_bcd(input int v);
		logic [DEC_W-1:0] r;
		r = '0;
		for (int i = 0; i < 5; i++) begin
			r[i*4 +: 4] = 4'(v % 10);
			v           = v / 10;
		end
		return r;
	endfunction : to_bcd

	// one query with its answer compared
	task automatic query(input query_sel_t s, input logic [WORD_W-1:0] exp);
		logic v;
		logic [WORD_W-1:0] b;
		logic [DEC_W-1:0] d;
		@(posedge clk_sys);
		i_status_host_model.ask(s, v, b, d);
		check(v, 1'b1);
		check(b, exp);
		if (s != QUERY_COMPLIANCE) check(d, to_bcd(int'(exp)));
	endtask : query

	// drive one condition bit and let the event land
	task automatic set_cond(input int idx, input logic val);
		@(posedge clk_sys);
		cond[idx] <= val;
		repeat (2) @(posedge clk_sys);
	endtask : set_cond

	// verdict and end of run
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finish_test

	// watchdog
	initial begin
		#2ms;
		err_total++;
		finish_test();
	end

	// ============================================================
	// tests
	// ============================================================
	initial begin
		logic [WORD_W-1:0] used, fall;
		logic v;
		logic [WORD_W-1:0] b;
		logic [DEC_W-1:0] d;
		cond           = '0;
		cond[16+8]     = 1'b1;  // bad calibration constant present at power-up
		rising_filter  = '1;
		falling_filter = '1;
		event_enable   = '0;
		repeat (8) @(posedge clk_sys);
		srst <= 1'b0;
		query(QUERY_DOUBTFUL, 16'h0100);
		query(QUERY_MEAS, EVENT_RESET);
		query(QUERY_ACTIVITY, EVENT_RESET);
		set_cond(16+8, 1'b0);
		query(QUERY_DOUBTFUL, 16'h0000);
		$display("test reset done");

		// every bit of every register, rising then falling
		for (int r = 0; r < 3; r++) begin
			used = (r == 0) ? MEAS_USED : (r == 1) ? DOUBT_USED : ACTIV_USED;
			fall = (r == 0) ? MEAS_FALL_OK : (r == 1) ? DOUBT_FALL_OK : ACTIV_FALL_OK;
			for (int i = 0; i < WORD_W; i++) begin
				set_cond(r*16+i, 1'b1);
				query(query_sel_t'(r), used[i] ? 16'(1 << i) : 16'h0000);
				query(query_sel_t'(r), 16'h0000);
				set_cond(r*16+i, 1'b0);
				query(query_sel_t'(r), (used[i] & fall[i]) ? 16'(1 << i) : 16'h0000);
			end
		end
		$display("test bit map done");

		// transition in the same cycle as the read survives the clear
		@(posedge clk_sys);
		cond[0] <= 1'b1;
		i_status_host_model.ask(QUERY_MEAS, v, b, d);
		check(b, 16'h0000);
		query(QUERY_MEAS, 16'h0001);
		$display("test read race done");

		// filters off: no edge is latched
		@(posedge clk_sys);
		rising_filter  <= '0;
		falling_filter <= '0;
		set_cond(0, 1'b0);
		set_cond(2, 1'b1);
		query(QUERY_MEAS, 16'h0000);
		set_cond(2, 1'b0);
		rising_filter  <= '1;
		falling_filter <= '1;
		$display("test filters off done");

		// enable masks gate the summary
		set_cond(5, 1'b1);
		#1;
		check(meas_summary, 1'b0);
		@(posedge clk_sys);
		event_enable[5] <= 1'b1;
		@(posedge clk_sys);
		#1;
		check(meas_summary, 1'b1);
		check(doubtful_summary, 1'b0);
		query(QUERY_MEAS, 16'h0020);
		#1;
		check(meas_summary, 1'b0);
		$display("test summary done");

		// error lamp follows doubtful conditions
		@(posedge clk_sys);
		cond[16+10]         <= 1'b1;
		event_enable[16+10] <= 1'b1;
		#1;
		check(error_lamp, 1'b1);
		@(posedge clk_sys);
		cond[16+10] <= 1'b0;
		#1;
		check(error_lamp, 1'b0);
		check(doubtful_summary, 1'b1);
		query(QUERY_DOUBTFUL, 16'h0400);
		#1;
		check(doubtful_summary, 1'b0);
		$display("test error lamp done");

		// compliance query reads the level and clears nothing
		set_cond(14, 1'b1);
		query(QUERY_COMPLIANCE, 16'h0001);
		query(QUERY_MEAS, 16'h4000);
		set_cond(14, 1'b0);
		query(QUERY_COMPLIANCE, 16'h0000);
		$display("test compliance done");

		// activity summary follows an enabled event
		@(posedge clk_sys);
		event_enable[32+10] <= 1'b1;
		set_cond(32+10, 1'b1);
		#1;
		check(activity_summary, 1'b1);
		query(QUERY_ACTIVITY, 16'h0400);
		#1;
		check(activity_summary, 1'b0);
		$display("test activity summary done");
		finish_test();
	end

endmodule : status_event_registers_tb
